// file: hdl/deeac_mem.sv
// Word memory for the data EEPROM array, registered read data.
// Assumes a single clock; one access per cycle.
`timescale 1ns/10ps
`default_nettype none
module deeac_mem #(
    parameter int DEPTH = 256,
    parameter int AW = 8,
    parameter int DW = 16
) (
    // Clock
    input wire logic clk_i,
    // Access
    input wire logic we_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] wdata_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= mem[addr_i];
    end
endmodule : deeac_mem
`default_nettype wire

// file: hdl/deeac_pkg.sv
// Package for the data EEPROM access block: widths, operation codes, timing.
// Assumes a 100 MHz system clock.
package deeac_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam int UPPER_W = 8;
    localparam int LOWER_W = 16;
    localparam int DATA_W = 16;
    localparam int WORDS = 256;
    localparam int IDX_W = 8;

    // ------------------------------------------------------------------
    // Reset values and fixed values
    // ------------------------------------------------------------------
    localparam logic [UPPER_W-1:0] UPPER_RST = 8'h00;
    localparam logic [LOWER_W-1:0] LOWER_RST = 16'h0000;
    localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;

    // ------------------------------------------------------------------
    // Timing: programming time per operation
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int PROG_TIME_NS = 200;
    localparam int PROG_CYC = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;

    // ------------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        DEEAC_OP_ERASE1 = 3'h0,
        DEEAC_OP_ERASE4 = 3'h1,
        DEEAC_OP_ERASE8 = 3'h2,
        DEEAC_OP_BULK = 3'h3,
        DEEAC_OP_WRITE = 3'h4
    } deeac_op_t;

endpackage : deeac_pkg

// file: hdl/deeac_top.sv
// Data EEPROM access logic: captures the table-write address into hidden
// holders and performs erase, bulk erase, word write and word read.
// Assumes the core issues one table operation at a time and waits on busy.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Target address is 24 bits: upper 8-bit holder and lower 16-bit holder.
// - Holders are hidden; they capture the address of the last low-word table write.
// - Address bit 0 is always zero; only even addresses are used.
// - Top bit of the upper holder always reads as zero.
// - The array is reached only by table read and table write.
// - Locations are 16 bits; high-word table accesses are ignored.
// - Erase covers one, four or eight words starting at the addressed word.
// - Bulk erase clears every location in one operation.
// - Single-word write and single-word read are supported.
module deeac_top
    import deeac_pkg::*;
#(
    parameter int WORDS_P = WORDS,
    parameter int IDX_W_P = IDX_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Table write, low and high word
    input wire logic tbl_wr_i,
    input wire logic table_write_high_word_i,
    input wire logic [ADDR_W-1:0] tbl_addr_i,
    input wire logic [DATA_W-1:0] tbl_wdata_i,
    // Table read, low and high word
    input wire logic tbl_rd_i,
    input wire logic table_read_high_word_i,
    // Operation start
    input wire logic start_i,
    input wire logic [2:0] op_i,
    // Results
    output logic [DATA_W-1:0] rdata_o,
    output logic rvalid_o,
    output logic busy_o,
    output logic [UPPER_W-1:0] nvm_addr_upper_holder_o,
    output logic [LOWER_W-1:0] nvm_addr_lower_holder_o
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_WRITE} deeac_st_t;

    typedef struct packed {
        deeac_st_t st;
        logic [UPPER_W-1:0] upper;
        logic [LOWER_W-1:0] lower;
        logic [DATA_W-1:0] latch;
        logic [DATA_W-1:0] rdata;
        logic [IDX_W_P-1:0] idx;
        logic [IDX_W_P-1:0] left;
        logic [15:0] tmr;
        logic rd_pend;
        logic rvalid;
        logic busy;
        logic wr_op;
    } deeac_state_t;

    deeac_state_t r;
    deeac_state_t next_r;

    logic mem_we;
    logic [IDX_W_P-1:0] mem_addr;
    logic [DATA_W-1:0] mem_wdata;
    logic [DATA_W-1:0] mem_rdata;
    logic [IDX_W_P-1:0] word_idx;

    // Word index from the byte address; bit 0 dropped
    assign word_idx = r.lower[IDX_W_P:1];

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.rvalid = 1'b0;
        mem_we = 1'b0;
        mem_addr = word_idx;
        mem_wdata = ERASED_WORD;
        if (r.rd_pend) begin
            next_r.rd_pend = 1'b0;
            next_r.rvalid = 1'b1;
            next_r.rdata = mem_rdata;
        end
        unique case (r.st)
            ST_IDLE: begin
                // Low-word table write captures address and data
                if (tbl_wr_i && !table_write_high_word_i) begin
                    next_r.upper = {1'b0, tbl_addr_i[ADDR_W-2:LOWER_W]};
                    next_r.lower = {tbl_addr_i[LOWER_W-1:1], 1'b0};
                    next_r.latch = tbl_wdata_i;
                end else if (tbl_rd_i && !table_read_high_word_i) begin
                    mem_addr = tbl_addr_i[IDX_W_P:1];
                    next_r.rd_pend = 1'b1;
                end else if (start_i) begin
                    next_r.busy = 1'b1;
                    next_r.tmr = 16'(PROG_CYC);
                    // Only a word write commits the latched data after the timed phase
                    next_r.wr_op = (op_i == DEEAC_OP_WRITE);
                    unique case (op_i)
                        DEEAC_OP_ERASE4: begin
                            next_r.st = ST_ERASE;
                            next_r.idx = word_idx;
                            next_r.left = IDX_W_P'(3);
                        end
                        DEEAC_OP_ERASE8: begin
                            next_r.st = ST_ERASE;
                            next_r.idx = word_idx;
                            next_r.left = IDX_W_P'(7);
                        end
                        DEEAC_OP_BULK: begin
                            next_r.st = ST_ERASE;
                            next_r.idx = '0;
                            next_r.left = IDX_W_P'(WORDS_P - 1);
                        end
                        DEEAC_OP_WRITE: begin
                            next_r.st = ST_WRITE;
                        end
                        default: begin
                            next_r.st = ST_ERASE;
                            next_r.idx = word_idx;
                            next_r.left = '0;
                        end
                    endcase
                end
            end
            ST_ERASE: begin
                mem_addr = r.idx;
                mem_we = 1'b1;
                next_r.idx = r.idx + IDX_W_P'(1);
                if (r.left == '0) begin
                    next_r.st = ST_WRITE;
                    next_r.latch = r.latch;
                end else begin
                    next_r.left = r.left - IDX_W_P'(1);
                end
            end
            ST_WRITE: begin
                // Program timer; erase completes here too
                if (r.tmr > 16'h0001) begin
                    next_r.tmr = r.tmr - 16'h0001;
                end else begin
                    next_r.st = ST_IDLE;
                    next_r.busy = 1'b0;
                end
            end
            default: next_r.st = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '{st: ST_IDLE, upper: UPPER_RST, lower: LOWER_RST, default: '0};
        end else begin
            r <= next_r;
        end
    end

    // Erase and word write share the timed phase; the word lands at its end
    logic wr_commit;
    assign wr_commit = (r.st == ST_WRITE) && (r.tmr <= 16'h0001) && r.wr_op;

    deeac_mem #(
        .DEPTH(WORDS_P),
        .AW(IDX_W_P),
        .DW(DATA_W)
    ) u_mem (
        .clk_i(clk_i),
        .we_i(mem_we | wr_commit),
        .addr_i(wr_commit ? word_idx : mem_addr),
        .wdata_i(wr_commit ? r.latch : mem_wdata),
        .rdata_o(mem_rdata)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rdata_o = r.rdata;
    assign rvalid_o = r.rvalid;
    assign busy_o = r.busy;
    assign nvm_addr_upper_holder_o = r.upper;
    assign nvm_addr_lower_holder_o = r.lower;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_upper_msb_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        nvm_addr_upper_holder_o[UPPER_W-1] == 1'b0) else $error("upper holder msb set");
    a_lower_lsb_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        nvm_addr_lower_holder_o[0] == 1'b0) else $error("lower holder lsb set");
    a_capture_addr: assert property (@(posedge clk_i) disable iff (rst_i)
        (!busy_o && tbl_wr_i && !table_write_high_word_i) |=>
        nvm_addr_lower_holder_o[LOWER_W-1:1] == $past(tbl_addr_i[LOWER_W-1:1]))
        else $error("address not captured");
    a_high_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
        (tbl_wr_i && table_write_high_word_i) |=> $stable(nvm_addr_lower_holder_o))
        else $error("high word write changed holder");
    a_busy_start: assert property (@(posedge clk_i) disable iff (rst_i)
        (!busy_o && start_i && !tbl_wr_i && !tbl_rd_i) |=> busy_o)
        else $error("busy not raised");
    a_busy_ends: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(busy_o) |-> ##[1:300] !busy_o) else $error("busy stuck");
    a_read_answer: assert property (@(posedge clk_i) disable iff (rst_i)
        (!busy_o && tbl_rd_i && !tbl_wr_i && !table_read_high_word_i) |=> ##1 rvalid_o)
        else $error("read not answered");
    a_bulk_len: assert property (@(posedge clk_i) disable iff (rst_i)
        (!busy_o && start_i && !tbl_wr_i && !tbl_rd_i && op_i == 3'h3) |=> busy_o [*8])
        else $error("bulk erase too short");
    // Four erase cycles, then the 20-cycle program time
    a_erase4_span: assert property (@(posedge clk_i) disable iff (rst_i)
        (!busy_o && start_i && !tbl_wr_i && !tbl_rd_i && op_i == 3'h1) |=>
        busy_o [*8] ##17 !busy_o) else $error("four word erase wrong length");
    // A word write holds busy for the program time only
    a_write_span: assert property (@(posedge clk_i) disable iff (rst_i)
        (!busy_o && start_i && !tbl_wr_i && !tbl_rd_i && op_i == 3'h4) |=>
        busy_o [*8] ##13 !busy_o) else $error("word write wrong length");
endmodule : deeac_top
`default_nettype wire

// file: sim/deeac_core_model.sv
// Core model: issues table writes, table reads and operation starts.
// Assumes the block's busy output and one shared clock.
`timescale 1ns/10ps
`default_nettype none
module deeac_core_model
    import deeac_pkg::*;
(
    // Clock and block status
    input wire logic clk_i,
    input wire logic busy_i,
    input wire logic rvalid_i,
    input wire logic [DATA_W-1:0] rdata_i,
    // Table requests and operation start
    output logic tbl_wr_o,
    output logic tw_hi_o,
    output logic tbl_rd_o,
    output logic tr_hi_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [DATA_W-1:0] wdata_o,
    output logic start_o,
    output logic [2:0] op_o
);
    initial begin
        {tbl_wr_o, tw_hi_o, tbl_rd_o, tr_hi_o, start_o} = 5'h00;
        addr_o = 24'h000000;
        wdata_o = 16'h0000;
        op_o = 3'h7;
    end

    // Hold off every request until programming has finished
    task automatic idle();
        @(posedge clk_i);
        while (busy_i) @(posedge clk_i);
    endtask : idle

    task automatic wr(input logic [23:0] a, input logic [15:0] d, input logic hi);
        idle();
        addr_o <= a;
        wdata_o <= d;
        tw_hi_o <= hi;
        tbl_wr_o <= 1'b1;
        @(posedge clk_i);
        tbl_wr_o <= 1'b0;
        tw_hi_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask : wr

    task automatic rd(input logic [23:0] a, input logic hi, output logic ok,
                      output logic [15:0] d);
        idle();
        addr_o <= a;
        tr_hi_o <= hi;
        tbl_rd_o <= 1'b1;
        @(posedge clk_i);
        tbl_rd_o <= 1'b0;
        tr_hi_o <= 1'b0;
        addr_o <= ~a;
        ok = 1'b0;
        d = 16'h0000;
        repeat (4) begin
            @(posedge clk_i);
            if (rvalid_i === 1'b1 && !ok) begin
                ok = 1'b1;
                d = rdata_i;
            end
        end
    endtask : rd

    // Start an operation and count the cycles that busy stands
    task automatic op(input logic [2:0] c, output int n);
        idle();
        op_o <= c;
        start_o <= 1'b1;
        @(posedge clk_i);
        start_o <= 1'b0;
        op_o <= ~c;
        n = 0;
        @(posedge clk_i);
        while (busy_i === 1'b1 && n < 400) begin
            n++;
            @(posedge clk_i);
        end
    endtask : op
endmodule : deeac_core_model
`default_nettype wire

// file: sim/deeac_top_bench.sv
// Bench for the data EEPROM access block: random writes, erases, reads.
// Assumes the core model drives every request input of the block.
`timescale 1ns/10ps
`default_nettype none
module deeac_top_bench;
    import deeac_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr, twh, rd, trh, start, rvalid, busy;
    logic [2:0] op;
    logic [23:0] addr, last_a, a;
    logic [15:0] wdata, rdata, d;
    logic [7:0] up;
    logic [15:0] lo;
    logic ok;
    logic [31:0] seed = 32'h00000057;
    logic [15:0] ref_mem [WORDS];
    int bad_count = 0;
    int n_tests = 0;
    int cyc = 0;

    deeac_top dut (.clk_i(clk), .rst_i(rst), .tbl_wr_i(wr), .table_write_high_word_i(twh),
        .tbl_addr_i(addr), .tbl_wdata_i(wdata), .tbl_rd_i(rd), .table_read_high_word_i(trh),
        .start_i(start), .op_i(op), .rdata_o(rdata), .rvalid_o(rvalid), .busy_o(busy),
        .nvm_addr_upper_holder_o(up), .nvm_addr_lower_holder_o(lo));
    deeac_core_model core (.clk_i(clk), .busy_i(busy), .rvalid_i(rvalid), .rdata_i(rdata),
        .tbl_wr_o(wr), .tw_hi_o(twh), .tbl_rd_o(rd), .tr_hi_o(trh), .addr_o(addr),
        .wdata_o(wdata), .start_o(start), .op_o(op));

    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            end_of_test();
        end
    end

    // ----------
    // Helpers
    // ----------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_tests++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test

    // Capture an address, check the holders, run one operation
    task automatic run(input logic [23:0] ta, input logic [15:0] td, input logic [2:0] c);
        int n;
        int w;
        core.wr(ta, td, 1'b0);
        @(posedge clk);
        chk("upper holder", 24'({1'b0, ta[22:16]}), 24'(up));
        chk("lower holder", 24'({ta[15:1], 1'b0}), 24'(lo));
        last_a = ta;
        core.op(c, n);
        w = (c == DEEAC_OP_ERASE4) ? 4 : (c == DEEAC_OP_ERASE8) ? 8 :
            (c == DEEAC_OP_BULK) ? WORDS : 1;
        chk("busy span", 24'((c == DEEAC_OP_WRITE) ? PROG_CYC : w + PROG_CYC), 24'(n));
        for (int k = 0; k < w; k++) begin
            ref_mem[8'(ta[8:1] + k)] = (c == DEEAC_OP_WRITE) ? td : ERASED_WORD;
        end
    endtask : run

    task automatic vrf(input logic [7:0] i);
        seed = xs(seed);
        core.rd({seed[23:9], i, seed[0]}, 1'b0, ok, d);
        chk("read valid", 24'h1, 24'(ok));
        chk("read data", 24'(ref_mem[i]), 24'(d));
    endtask : vrf

    // ----------
    // Sequence
    // ----------
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("reset holders", 24'h0, {up, lo});
        chk("reset status", 24'h0, {6'h0, busy, rvalid, rdata});
        seed = xs(seed);
        run(seed[23:0], 16'h0000, DEEAC_OP_BULK);
        vrf(8'h00);
        vrf(8'hff);
        run(24'hffffff, 16'ha5c3, DEEAC_OP_WRITE);
        vrf(8'hff);
        repeat (12) begin
            seed = xs(seed);
            run(seed[23:0], seed[31:16], DEEAC_OP_WRITE);
            vrf(last_a[8:1]);
        end
        for (int c = 0; c < 3; c++) begin
            seed = xs(seed);
            a = {seed[23:9], 1'b0, 1'b1 + seed[7:1], seed[0]};
            for (int k = -1; k < 9; k++) begin
                seed = xs(seed);
                run({a[23:9], 8'(a[8:1] + k), 1'b0}, seed[15:0], DEEAC_OP_WRITE);
            end
            run(a, 16'h0000, 3'(c));
            for (int k = -1; k < 9; k++) vrf(8'(a[8:1] + k));
        end
        seed = xs(seed);
        core.wr(seed[23:0], seed[31:16], 1'b1);
        @(posedge clk);
        chk("high write ignored", 24'({1'b0, last_a[22:16]}), 24'(up));
        core.rd(seed[23:0], 1'b1, ok, d);
        chk("high read ignored", 24'h0, 24'(ok));
        for (int i = 0; i < WORDS; i++) vrf(8'(i));
        end_of_test();
    end
endmodule : deeac_top_bench
`default_nettype wire
